// File: rtl/serial_command_line_handler.sv
// Character-level front end of the serial command port.
// Assumes a byte receiver and transmitter outside, a parser reading the line
// buffer, and an output processor feeding response bytes; one clock domain.
//
// Overview of operation
// - CR or LF hands the line over
// - ESC clears line, answers CR LF
// - BS drops last char, never a terminator
// - Only seven control characters are acted upon
// - After parsing, send CR LF back
// - XON restarts transmitter under flow control
// - XOFF halts transmitter under flow control
// - CAN resets pointers and empties both queues
// - XOFF posts queue error -400
// - After XON drain queue, then send '!'
// - Echo data bytes; BS as BS SP BS
// - CR LF pair echoes first byte only
// - Lost echo sends NAK, logs error
// - Flow terminator answers XOFF CR or XOFF
// - Eight data bits, no parity, echo default
// - Output commands need remote mode first
`timescale 1ns/1ps
`include "cmd_line_consts.svh"

module serial_command_line_handler (
    input  wire logic                  core_clk,      // System clock, 40 MHz
    input  wire logic                  rst,           // Synchronous reset
    input  wire logic                  rx_valid,      // Received byte present
    input  wire logic [7:0]            rx_data,       // Received byte
    output logic                       rx_ready,      // Byte taken
    output logic                       tx_valid,      // Byte to send
    output logic [7:0]                 tx_data,       // Byte to send
    input  wire logic                  tx_ready,      // Transmitter took byte
    input  wire logic                  echo_en,       // Echo mode on
    input  wire logic                  flow_en,       // XON/XOFF on
    output logic                       line_valid,    // Line ready for parser
    output logic [7:0]                 line_len,      // Chars incl. terminator
    input  wire logic [6:0]            line_rd_addr,  // Parser read address
    output logic [7:0]                 line_rd_data,  // Parser read data
    input  wire logic                  parse_done,    // Commands forwarded
    input  wire logic                  resp_valid,    // Response byte present
    input  wire logic [7:0]            resp_data,     // Response byte
    output logic                       resp_ready,    // Response byte taken
    input  wire logic                  remote_set,    // Remote mode selected
    input  wire logic                  remote_clr,    // Local mode selected
    input  wire logic                  out_cmd_req,   // Output command wants to run
    output logic                       out_cmd_ok,    // Command may run
    output logic                       out_cmd_refused, // Command refused
    output cmd_line_pkg::err_evt_t     err_evt        // Error queue entry
);

    // Byte storage
    logic [7:0]             line_mem [`LINE_DEPTH];   // Input line buffer
    logic [7:0]             txq_mem  [`TXQ_DEPTH];    // Transmit queue

    // State and its next value
    cmd_line_pkg::state_t   st_q;                    // Registered state
    cmd_line_pkg::state_t   st_d;                    // Next state

    // Combinational side signals
    logic                   rx_take;                 // Byte accepted
    logic                   pop;                     // Byte leaves queue
    logic                   push;                    // Byte enters queue
    logic [7:0]             push_b;                  // Byte entering queue
    logic                   line_we;                 // Line buffer write
    logic [6:0]             line_wa;                 // Line buffer address
    logic                   q_full;                  // Queue full
    logic                   q_flush;                 // Queue emptied by CAN

    // Terminator test
    function automatic logic is_term(input logic [7:0] c);
        is_term = (c == `CH_CR) || (c == `CH_LF);
    endfunction

    // Room for a number of echo bytes, keeping one slot spare
    function automatic logic fits(input logic [4:0] cnt, input logic [4:0] need);
        fits = ({1'b0, cnt} + {1'b0, need}) < {1'b0, `TXQ_DEPTH};
    endfunction

    // Handshakes
    assign q_full     = (st_q.q_cnt == `TXQ_DEPTH);
    assign tx_valid   = (st_q.q_cnt != 5'h00) && !st_q.halt;
    assign pop        = tx_valid && tx_ready;
    assign rx_ready   = (st_q.st == cmd_line_pkg::ST_IDLE) && (st_q.seq_n == 2'h0);
    assign rx_take    = rx_valid && rx_ready;
    assign resp_ready = (st_q.seq_n == 2'h0) && !st_q.nak && !q_full
                        && !(st_q.bang && st_q.q_cnt == 5'h00) && !rx_take;

    // Outputs from registered state, error code constant
    assign tx_data         = txq_mem[st_q.q_rd];
    assign line_valid      = st_q.line_pulse;
    assign line_len        = st_q.line_cnt;
    assign out_cmd_ok      = st_q.ok;
    assign out_cmd_refused = st_q.refused;
    assign err_evt.valid   = st_q.err_v;
    assign err_evt.code    = `QERR_CODE;

    // Next-state logic
    always_comb begin
        st_d            = st_q;
        st_d.line_pulse = 1'b0;
        st_d.ok         = 1'b0;
        st_d.refused    = 1'b0;
        st_d.err_v      = 1'b0;
        push            = 1'b0;
        push_b          = `CH_NUL;
        line_we         = 1'b0;
        line_wa         = st_q.line_cnt[6:0];
        q_flush         = 1'b0;

        // Queue feed, pending responses first
        if (st_q.seq_n != 2'h0 && !q_full) begin
            push       = 1'b1;
            push_b     = st_q.seq_b[23:16];
            st_d.seq_b = {st_q.seq_b[15:0], `CH_NUL};
            st_d.seq_n = st_q.seq_n - 2'h1;
        end else if (st_q.nak && !q_full) begin
            // Lost echo marker
            push     = 1'b1;
            push_b   = `CH_NAK;
            st_d.nak = 1'b0;
        end else if (st_q.bang && st_q.q_cnt == 5'h00 && !st_q.halt) begin
            // Queue drained after XON, report idle
            push      = 1'b1;
            push_b    = `CH_BANG;
            st_d.bang = 1'b0;
        end else if (resp_valid && resp_ready) begin
            // Output processor response byte
            push   = 1'b1;
            push_b = resp_data;
        end

        // Received byte handling, eight data bits, no parity
        if (rx_take) begin
            st_d.prev_term = is_term(rx_data);
            st_d.prev_byte = rx_data;
            if (is_term(rx_data)) begin
                if (st_q.prev_term && rx_data != st_q.prev_byte) begin
                    // Second byte of a CR LF or LF CR pair swallowed
                    st_d.prev_term = 1'b0;
                end else begin
                    // Store terminator and hand the line over
                    line_we         = 1'b1;
                    st_d.line_cnt   = st_q.line_cnt + 8'h01;
                    st_d.st         = cmd_line_pkg::ST_PARSE;
                    st_d.line_pulse = 1'b1;
                    if (flow_en) begin
                        // Stop the host while the line is parsed
                        st_d.seq_b = {`CH_XOFF, `CH_CR, `CH_NUL};
                        st_d.seq_n = echo_en ? 2'h2 : 2'h1;
                    end else if (echo_en) begin
                        // Echo the first terminator only
                        st_d.seq_b = {rx_data, `CH_NUL, `CH_NUL};
                        st_d.seq_n = 2'h1;
                    end
                end
            end else begin
                unique case (rx_data)
                    `CH_ESC: begin
                        // Resynchronise: empty line, answer CR LF
                        st_d.line_cnt = 8'h00;
                        st_d.seq_b    = {`CH_CR, `CH_LF, `CH_NUL};
                        st_d.seq_n    = 2'h2;
                    end
                    `CH_BS: begin
                        // Drop last character unless it ends a line
                        if (st_q.line_cnt != 8'h00
                            && !is_term(line_mem[st_q.line_cnt[6:0] - 7'h01])) begin
                            st_d.line_cnt = st_q.line_cnt - 8'h01;
                        end
                        if (echo_en) begin
                            if (fits(st_q.q_cnt, 5'h03)) begin
                                st_d.seq_b = {`CH_BS, `CH_SPACE, `CH_BS};
                                st_d.seq_n = 2'h3;
                            end else begin
                                st_d.nak   = 1'b1;
                                st_d.err_v = 1'b1;
                            end
                        end
                    end
                    `CH_XON: begin
                        // Restart transmitter, owe idle marker
                        if (flow_en) begin
                            st_d.halt = 1'b0;
                            st_d.bang = 1'b1;
                        end
                    end
                    `CH_XOFF: begin
                        // Halt transmitter, log lost information
                        if (flow_en) begin
                            st_d.halt  = 1'b1;
                            st_d.err_v = 1'b1;
                        end
                    end
                    `CH_CAN: begin
                        // Reset both pointers and queues
                        st_d.line_cnt = 8'h00;
                        st_d.seq_n    = 2'h0;
                        st_d.nak      = 1'b0;
                        st_d.bang     = 1'b0;
                        q_flush       = 1'b1;
                    end
                    default: begin
                        if (rx_data > `CTRL_MAX) begin
                            // Ordinary character, kept while room remains
                            if (st_q.line_cnt < `LINE_MAX) begin
                                line_we       = 1'b1;
                                st_d.line_cnt = st_q.line_cnt + 8'h01;
                            end
                            if (echo_en) begin
                                if (fits(st_q.q_cnt, 5'h01)) begin
                                    st_d.seq_b = {rx_data, `CH_NUL, `CH_NUL};
                                    st_d.seq_n = 2'h1;
                                end else begin
                                    st_d.nak   = 1'b1;
                                    st_d.err_v = 1'b1;
                                end
                            end
                        end
                        // Other control bytes are ignored
                    end
                endcase
            end
        end

        // Parser completion
        if (st_q.st == cmd_line_pkg::ST_PARSE) begin
            if (parse_done) begin
                st_d.done = 1'b1;
            end
            if ((st_q.done || parse_done) && st_q.seq_n == 2'h0) begin
                // Line consumed, answer CR LF
                st_d.done     = 1'b0;
                st_d.st       = cmd_line_pkg::ST_IDLE;
                st_d.line_cnt = 8'h00;
                st_d.seq_b    = {`CH_CR, `CH_LF, `CH_NUL};
                st_d.seq_n    = 2'h2;
            end
        end

        // Transmit queue pointers
        if (q_flush) begin
            st_d.q_wr  = 4'h0;
            st_d.q_rd  = 4'h0;
            st_d.q_cnt = 5'h00;
        end else begin
            if (push) begin
                st_d.q_wr = st_q.q_wr + 4'h1;
            end
            if (pop) begin
                st_d.q_rd = st_q.q_rd + 4'h1;
            end
            if (push && !pop) begin
                st_d.q_cnt = st_q.q_cnt + 5'h01;
            end else if (pop && !push) begin
                st_d.q_cnt = st_q.q_cnt - 5'h01;
            end
        end

        // Remote mode and output command gate
        if (remote_set) begin
            st_d.remote = 1'b1;
        end else if (remote_clr) begin
            st_d.remote = 1'b0;
        end
        if (out_cmd_req) begin
            st_d.ok      = st_q.remote;
            st_d.refused = !st_q.remote;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Byte memories and parser read port
    always_ff @(posedge core_clk) begin
        if (line_we) begin
            line_mem[line_wa] <= rx_data;
        end
        if (push && !q_flush) begin
            txq_mem[st_q.q_wr] <= push_b;
        end
        if (rst) begin
            line_rd_data <= 8'h00;
        end else begin
            line_rd_data <= line_mem[line_rd_addr];
        end
    end

    // Checks
    a_esc_answer: assert property (@(posedge core_clk) disable iff (rst)
        rx_take && rx_data == `CH_ESC |=> st_q.seq_n == 2'h2 && st_q.seq_b[23:16] == `CH_CR
                                          && st_q.line_cnt == 8'h00)
        else $error("ESC did not clear line and queue CR LF");

    a_term_handoff: assert property (@(posedge core_clk) disable iff (rst)
        rx_take && is_term(rx_data) && !st_q.prev_term |=> line_valid && !rx_ready)
        else $error("Terminator did not hand line to parser");

    a_halt_blocks: assert property (@(posedge core_clk) disable iff (rst)
        st_q.halt |-> !tx_valid)
        else $error("Transmit while halted");

    a_xoff_error: assert property (@(posedge core_clk) disable iff (rst)
        rx_take && flow_en && rx_data == `CH_XOFF |=> err_evt.valid && err_evt.code == 16'hFE70)
        else $error("XOFF did not log queue error");

    a_xon_release: assert property (@(posedge core_clk) disable iff (rst)
        rx_take && flow_en && rx_data == `CH_XON |=> !st_q.halt && (st_q.bang || $past(st_q.bang)))
        else $error("XON did not release transmitter");

    a_can_flush: assert property (@(posedge core_clk) disable iff (rst)
        rx_take && rx_data == `CH_CAN |=> st_q.q_cnt == 5'h00 && st_q.line_cnt == 8'h00
                                          && st_q.seq_n == 2'h0)
        else $error("CAN did not empty queues");

    a_bs_echo: assert property (@(posedge core_clk) disable iff (rst)
        rx_take && echo_en && rx_data == `CH_BS && fits(st_q.q_cnt, 5'h03)
        |=> st_q.seq_n == 2'h3 ##1 st_q.seq_n == 2'h2 || q_full)
        else $error("Backspace echo not three bytes");

    a_remote_gate: assert property (@(posedge core_clk) disable iff (rst)
        out_cmd_req && !st_q.remote |=> out_cmd_refused && !out_cmd_ok)
        else $error("Output command ran without remote mode");

    a_line_limit: assert property (@(posedge core_clk) disable iff (rst)
        st_q.st == cmd_line_pkg::ST_IDLE |-> st_q.line_cnt <= `LINE_MAX)
        else $error("Line buffer over 127 characters");

    a_parse_crlf: assert property (@(posedge core_clk) disable iff (rst)
        st_q.st == cmd_line_pkg::ST_PARSE && parse_done && st_q.seq_n == 2'h0
        |=> st_q.seq_n == 2'h2 && st_q.seq_b[23:16] == `CH_CR ##[1:20] st_q.seq_n == 2'h0)
        else $error("CR LF not sent after parse");

endmodule // serial_command_line_handler

// File: rtl/cmd_line_consts.svh
// Character codes, sizes and event codes for the serial command line handler.
// Assumes nothing beyond a SystemVerilog compiler; definitions only.
`ifndef CMD_LINE_CONSTS_SVH
`define CMD_LINE_CONSTS_SVH

// Control characters acted upon, then reply bytes and filler
`define CH_LF        8'h0A
`define CH_CR        8'h0D
`define CH_BS        8'h08
`define CH_ESC       8'h1B
`define CH_XON       8'h11
`define CH_XOFF      8'h13
`define CH_CAN       8'h18
`define CH_NAK       8'h15
`define CH_SPACE     8'h20
`define CH_BANG      8'h21
`define CH_NUL       8'h00

// Top of the control range
`define CTRL_MAX     8'h1F

// Line buffer: 127 characters plus a terminator
`define LINE_DEPTH   128
`define LINE_MAX     8'h7F

// Transmit queue depth and pointer width
`define TXQ_DEPTH    5'h10
`define TXQ_AW       4

// Queue error code, -400 as 16-bit two's complement
`define QERR_CODE    16'hFE70

`endif

// File: rtl/cmd_line_pkg.sv
// Types shared by the serial command line handler and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler; widths here are written as literals.
package cmd_line_pkg;

    // Line handling phase
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_PARSE
    } phase_t;

    // Error queue event toward the error queue
    typedef struct packed {
        logic        valid;   // One-cycle pulse
        logic [15:0] code;    // Signed error code
    } err_evt_t;

    // Whole state of the handler
    typedef struct packed {
        phase_t      st;         // Collecting or waiting for the parser
        logic [7:0]  line_cnt;   // Characters held in the line buffer
        logic [23:0] seq_b;      // Pending response bytes, oldest on top
        logic [1:0]  seq_n;      // Number of pending response bytes
        logic [3:0]  q_wr;       // Transmit queue write pointer
        logic [3:0]  q_rd;       // Transmit queue read pointer
        logic [4:0]  q_cnt;      // Transmit queue fill
        logic        halt;       // Transmitter stopped by XOFF
        logic        bang;       // Idle marker owed after XON
        logic        nak;        // Lost-echo marker owed
        logic        done;       // Parser finished, CR LF owed
        logic        prev_term;  // Last byte was a terminator that handed over a line
        logic [7:0]  prev_byte;  // Last byte received
        logic        line_pulse; // Line handed to parser
        logic        remote;     // Remote mode selected
        logic        ok;         // Output command allowed
        logic        refused;    // Output command refused
        logic        err_v;      // Queue error pulse
    } state_t;

endpackage

// File: bench/host_model.sv
// Host computer model: offers bytes on the receive handshake, collects replies.
// Assumes the bench calls send and reads got; one clock domain.
`timescale 1ns/1ps

module host_model (
    input  wire logic       core_clk, // System clock
    input  wire logic       rx_ready, // Device took byte
    input  wire logic       tx_valid, // Device offers byte
    input  wire logic [7:0] tx_data,  // Offered reply byte
    input  wire logic       slow,     // Stall the device transmitter
    output logic            rx_valid, // Byte offered
    output logic [7:0]      rx_data,  // Offered byte
    output logic            tx_ready  // Reply byte accepted
);
    logic [7:0] got[$]; // Reply bytes, oldest first
    int         misses; // Offers never taken

    // Idle levels at time zero
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'hA5;
        tx_ready = 1'b0;
        misses   = 0;
    end

    // Hold a byte until taken, then show a changed value
    task automatic send(input logic [7:0] b);
        int i;
        @(posedge core_clk);
        rx_valid <= 1'b1;
        rx_data  <= b;
        for (i = 0; i < 300; i++) begin
            @(posedge core_clk);
            if (rx_ready === 1'b1) break;
        end
        if (i == 300) misses++;
        rx_valid <= 1'b0;
        rx_data  <= ~b;
    endtask

    // Take replies promptly, or stall when asked
    always @(posedge core_clk) begin
        tx_ready <= ~slow;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
    end
endmodule // host_model

// File: bench/serial_command_line_handler_tb.sv
// Self-checking bench for the serial command line handler.
// Assumes host_model on the serial side; parser and output side driven here.
`timescale 1ns/1ps
`include "cmd_line_consts.svh"

module serial_command_line_handler_tb;
    logic                   core_clk, rst, slow, echo_en, flow_en;             // Clock, reset, modes
    logic                   rx_valid, rx_ready, tx_valid, tx_ready;            // Byte handshakes
    logic                   line_valid, parse_done, resp_valid, resp_ready;    // Parser, responses
    logic                   remote_set, remote_clr, out_cmd_req, out_cmd_ok, out_cmd_refused; // Gate
    logic [7:0]             rx_data, tx_data, line_len, line_rd_data, resp_data; // Byte buses
    logic [6:0]             line_rd_addr;                                      // Parser read address
    cmd_line_pkg::err_evt_t err_evt;                                           // Error entry
    int                     miscompares, comparisons, lines, errs, oks, refs;  // Counters
    logic [7:0]             last_len;                                          // Length handed over
    logic [15:0]            last_code;                                         // Last error code

    serial_command_line_handler dut (.core_clk(core_clk), .rst(rst), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .echo_en(echo_en), .flow_en(flow_en), .line_valid(line_valid),
        .line_len(line_len), .line_rd_addr(line_rd_addr), .line_rd_data(line_rd_data),
        .parse_done(parse_done), .resp_valid(resp_valid), .resp_data(resp_data),
        .resp_ready(resp_ready), .remote_set(remote_set), .remote_clr(remote_clr),
        .out_cmd_req(out_cmd_req), .out_cmd_ok(out_cmd_ok), .out_cmd_refused(out_cmd_refused),
        .err_evt(err_evt));

    host_model host (.core_clk(core_clk), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));

    // 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Count pulses seen on the design's outputs
    always @(posedge core_clk) begin
        if (line_valid === 1'b1) begin
            lines++;
            last_len = line_len;
        end
        if (err_evt.valid === 1'b1) begin
            errs++;
            last_code = err_evt.code;
        end
        if (out_cmd_ok === 1'b1) oks++;
        if (out_cmd_refused === 1'b1) refs++;
    end

    // Compare one value
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Wait for n reply bytes, compare them packed oldest first, then forget them
    task automatic expect_tx(input string name, input int n, input logic [31:0] exp);
        logic [31:0] seen;
        int          i;
        seen = '0;
        for (i = 0; i < 400 && host.got.size() < n; i++) @(posedge core_clk);
        repeat (4) @(posedge core_clk);
        check(name, host.got.size(), n);
        foreach (host.got[k]) seen = {seen[23:0], host.got[k]};
        host.got.delete();
        check(name, seen, exp);
    endtask

    // Nothing may come back
    task automatic quiet(input string name);
        repeat (30) @(posedge core_clk);
        check(name, host.got.size(), 0);
    endtask

    // Terminate a line, let the parser finish, expect echo then CR LF
    task automatic end_line(input logic [7:0] exp_len);
        int n;
        int i;
        n = lines;
        host.send(`CH_CR);
        for (i = 0; i < 100 && lines == n; i++) @(posedge core_clk);
        check("line handed over", lines, n + 1);
        check("line length", last_len, exp_len);
        parse_done <= 1'b1;
        @(posedge core_clk);
        parse_done <= 1'b0;
        expect_tx("echo then cr lf", 3, 32'h000D0D0A);
    endtask

    // Data echo, backspace echo, ignored control byte
    task automatic s_echo();
        host.send(8'h41);
        expect_tx("data echo", 1, 32'h41);
        host.send(`CH_BS);
        expect_tx("backspace echo", 3, 32'h082008);
        host.send(8'h01);
        quiet("ignored control");
    endtask

    // Line after backspace holds one char plus terminator; paired LF swallowed
    task automatic s_line();
        int n;
        host.send(8'h5A);
        expect_tx("data echo", 1, 32'h5A);
        end_line(8'h02);
        repeat (2) @(posedge core_clk);
        check("buffer char", line_rd_data, 8'h5A);
        line_rd_addr <= 7'h01;
        repeat (2) @(posedge core_clk);
        check("buffer term", line_rd_data, `CH_CR);
        n = lines;
        host.send(`CH_LF);
        quiet("paired lf");
        check("paired lf no line", lines, n);
    endtask

    // Escape empties the line and answers CR LF
    task automatic s_esc();
        host.send(8'h51);
        host.send(`CH_ESC);
        expect_tx("escape", 3, 32'h510D0A);
        end_line(8'h01);
    endtask

    // XOFF halts and logs, XON drains then marks idle, terminator answer
    task automatic s_flow();
        flow_en <= 1'b1;
        host.send(`CH_XOFF);
        repeat (3) @(posedge core_clk);
        check("xoff error", errs, 1);
        check("xoff code", last_code, `QERR_CODE);
        host.send(8'h42);
        quiet("halted");
        host.send(`CH_XON);
        expect_tx("drain then bang", 2, 32'h4221);
        host.send(`CH_CR);
        expect_tx("flow terminator", 2, 32'h130D);
        parse_done <= 1'b1;
        @(posedge core_clk);
        parse_done <= 1'b0;
        expect_tx("after parse", 2, 32'h0D0A);
        echo_en <= 1'b0;
        host.send(8'h43);
        host.send(`CH_LF);
        expect_tx("flow no echo", 1, 32'h13);
        parse_done <= 1'b1;
        @(posedge core_clk);
        parse_done <= 1'b0;
        expect_tx("after parse no echo", 2, 32'h0D0A);
        {flow_en, echo_en} <= 2'b01;
    endtask

    // Cancel empties a stalled queue and the line
    task automatic s_can();
        slow <= 1'b1;
        host.send(8'h43);
        host.send(8'h44);
        host.send(`CH_CAN);
        repeat (3) @(posedge core_clk);
        slow <= 1'b0;
        quiet("cancel");
        end_line(8'h01);
    endtask

    // Echo overflow while stalled, a short line well under 127 chars
    task automatic s_nak();
        int base;
        int i;
        base = errs;
        slow <= 1'b1;
        repeat (17) host.send(8'h78);
        repeat (5) @(posedge core_clk);
        slow <= 1'b0;
        for (i = 0; i < 300 && tx_valid !== 1'b0; i++) @(posedge core_clk);
        check("nak last", host.got[$], `CH_NAK);
        check("nak logged", errs > base, 1);
        host.got.delete();
        host.send(`CH_ESC);
        expect_tx("clear", 2, 32'h0D0A);
    endtask

    // Remote gate on output commands, then one response byte
    task automatic s_remote();
        int i;
        out_cmd_req <= 1'b1;
        @(posedge core_clk);
        out_cmd_req <= 1'b0;
        remote_set  <= 1'b1;
        @(posedge core_clk);
        remote_set  <= 1'b0;
        out_cmd_req <= 1'b1;
        @(posedge core_clk);
        out_cmd_req <= 1'b0;
        remote_clr  <= 1'b1;
        @(posedge core_clk);
        remote_clr  <= 1'b0;
        out_cmd_req <= 1'b1;
        @(posedge core_clk);
        out_cmd_req <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("refused", refs, 2);
        check("allowed", oks, 1);
        resp_valid <= 1'b1;
        resp_data  <= 8'h52;
        for (i = 0; i < 100; i++) begin
            @(posedge core_clk);
            if (resp_ready === 1'b1) break;
        end
        resp_valid <= 1'b0;
        resp_data  <= 8'hAD;
        expect_tx("response", 1, 32'h52);
    endtask

    // Counts and verdict
    task automatic summarize();
        if (host.misses != 0) miscompares++;
        $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge core_clk);
        miscompares++;
        summarize();
    end

    // Main sequence
    initial begin
        {rst, echo_en} = 2'b11;
        {flow_en, slow, parse_done, resp_valid, remote_set, remote_clr, out_cmd_req} = '0;
        resp_data    = 8'h00;
        line_rd_addr = 7'h00;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        s_echo();
        s_line();
        s_esc();
        s_flow();
        s_can();
        s_nak();
        s_remote();
        summarize();
    end
endmodule // serial_command_line_handler_tb
